// File: hw/pmg_pkg.sv
/*
 * Constants for the page-gated management register block.
 * Assumes a 100 MHz system clock and an APB master on the same clock.
 */
package pmg_pkg;
   // ==========================================================
   // apb register offsets (byte addresses)
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_IRQ = 8'h08;
   localparam logic [7:0] A_MASK = 8'h0C;
   localparam logic [7:0] A_C45A = 8'h10;
   // ==========================================================
   // apb fields and reset values
   localparam int CTRL_AUTO_MEDIA = 0;
   localparam int CTRL_FX = 1;
   localparam int STAT_LOOP = 16;
   localparam int STAT_FLF = 17;
   localparam int STAT_FIB = 18;
   localparam int IRQ_WR = 0;
   localparam int IRQ_RD = 1;
   localparam int IRQ_LPI = 2;
   localparam int IRQ_W = 3;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;
   // ==========================================================
   // management register map
   localparam logic [4:0] R_CTRL = 5'h00;
   localparam logic [4:0] R_PAGE = 5'h1F;
   localparam logic [4:0] R_FLF = 5'h13;
   localparam logic [4:0] R_FSTAT = 5'h18;
   localparam logic [15:0] PG_FLF = 16'h0001;
   localparam logic [15:0] PG_FSTAT = 16'h0003;
   localparam int LOOP_BIT = 14;
   localparam int FLF_BIT = 4;
   localparam int FSTAT_BIT = 2;
   localparam logic [4:0] C45_DEV = 5'h03;
   localparam logic [15:0] C45_PCS = 16'h0001;
   localparam logic [15:0] C45_EEE = 16'h0016;
   localparam int LPI_RX_BIT = 10;
   localparam int LPI_TX_BIT = 11;
   localparam logic [15:0] REG_RST = 16'h0000;
   // ==========================================================
   // frame format
   localparam logic [5:0] PRE_LEN = 6'h20;
   localparam logic [3:0] HDR_LAST = 4'hC;
   localparam logic [3:0] DAT_LAST = 4'hF;
   localparam logic [1:0] OP22_WR = 2'b01;
   localparam logic [1:0] OP22_RD = 2'b10;
   localparam logic [1:0] OP45_ADR = 2'b00;
   localparam logic [1:0] OP45_RD = 2'b11;
   localparam logic [1:0] OP45_RDI = 2'b10;
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_HDR = 2'b01,
      S_TA = 2'b11,
      S_DAT = 2'b10
   } pmg_state_type;
endpackage : pmg_pkg

// File: hw/pmg_top.sv
/*
 * Management register block: serial management slave with page-gated
 * clause 45 access, plus an apb register port.
 * Assumes mdc_i/mdio_i come from the station manager asynchronously and
 * event inputs come from logic on clk_i.
 */
// Summary of operation
// - reading 3.22 clears it only while page selector is zero
// - 3.22 reads back zero whenever page selector is nonzero
// - reading 3.1 clears lpi received bits only at page zero
// - clause 45 address post-increments only on post-read-increment reads at page zero
// - page 1 register 19 bit 4 enables fast link fail on all ports
// - control bit 14 loopback, ineffective while auto media sense is on
// - page 3 register 24 bit 2 shows 1000base-x fiber link only
// - serial data sampled on rising management clock edge
`timescale 1ns/1ps
module pmg_top
   import pmg_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR = 5'h00
)(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic mdc_i,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe_o,
   input wire logic rx_lpi_i,
   input wire logic tx_lpi_i,
   input wire logic wake_err_i,
   input wire logic fiber_link_i,
   output logic loopback_o,
   output logic [3:0] flf_en_o,
   output logic irq_o
);
   // ==========================================================
   // synchronisers
   logic [2:0] mdc_q;
   logic [1:0] mdio_q;
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         mdc_q <= 3'h0;
         mdio_q <= 2'h3;
      end
      else
      begin
         mdc_q <= {mdc_q[1:0], mdc_i};
         mdio_q <= {mdio_q[0], mdio_i};
      end
   end
   logic rise;
   logic bit_w;
   assign rise = mdc_q[1] & ~mdc_q[2];
   assign bit_w = mdio_q[1];

   // ==========================================================
   // management registers
   logic [15:0] ctl_q;
   logic [15:0] page_q;
   logic [15:0] ext19_q;
   logic [15:0] c45a_q;
   logic [15:0] eee_q;
   logic lpi_rx_q;
   logic lpi_tx_q;
   logic [1:0] apb_ctl_q;

   // ==========================================================
   // frame engine
   pmg_state_type st_q;
   logic [5:0] pre_q;
   logic [3:0] cnt_q;
   logic [12:0] hdr_q;
   logic [15:0] sh_q;
   logic rd_q;
   logic c45_q;
   logic [1:0] op_q;
   logic [4:0] reg_q;
   logic [12:0] hdr_w;
   logic hdr_hit;
   logic is_rd;
   logic wr_done;
   logic rd_go;
   logic [15:0] wr_val;
   logic [15:0] rd_val;
   logic page0;
   assign hdr_w = {hdr_q[11:0], bit_w};
   assign page0 = (page_q == REG_RST);
   assign hdr_hit = rise & (st_q == S_HDR) & (cnt_q == HDR_LAST)
                    & (hdr_w[9:5] == PHY_ADDR);
   assign is_rd = hdr_w[12] ? (hdr_w[11:10] == OP22_RD)
                            : hdr_w[11];
   assign rd_go = hdr_hit & is_rd;
   assign wr_done = rise & (st_q == S_DAT) & ~rd_q & (cnt_q == DAT_LAST);
   assign wr_val = {sh_q[14:0], bit_w};

   always_comb
   begin
      rd_val = REG_RST;
      if (hdr_w[12])
      begin
         unique case (hdr_w[4:0])
            R_CTRL: rd_val = ctl_q;
            R_PAGE: rd_val = page_q;
            R_FLF: rd_val = (page_q == PG_FLF) ? ext19_q : REG_RST;
            R_FSTAT:
               if (page_q == PG_FSTAT)
                  rd_val[FSTAT_BIT] = fiber_link_i & ~apb_ctl_q[CTRL_FX];
            default: rd_val = REG_RST;
         endcase
      end
      else if (hdr_w[4:0] == C45_DEV && page0)
      begin
         // nonzero page hides 3.22 and 3.1 entirely
         if (c45a_q == C45_EEE)
            rd_val = eee_q;
         else if (c45a_q == C45_PCS)
         begin
            rd_val[LPI_RX_BIT] = lpi_rx_q;
            rd_val[LPI_TX_BIT] = lpi_tx_q;
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         st_q <= S_IDLE;
         pre_q <= 6'h0;
         cnt_q <= 4'h0;
         hdr_q <= 13'h0;
         sh_q <= REG_RST;
         rd_q <= 1'b0;
         c45_q <= 1'b0;
         op_q <= 2'h0;
         reg_q <= 5'h0;
         mdio_o <= 1'b1;
         mdio_oe_o <= 1'b0;
      end
      else if (rise)
      begin
         unique case (st_q)
            S_IDLE:
            begin
               if (bit_w)
                  pre_q <= (pre_q == PRE_LEN) ? pre_q : pre_q + 6'h1;
               else
               begin
                  pre_q <= 6'h0;
                  if (pre_q == PRE_LEN)
                  begin
                     st_q <= S_HDR;
                     cnt_q <= 4'h0;
                  end
               end
            end
            S_HDR:
            begin
               hdr_q <= hdr_w;
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == HDR_LAST)
               begin
                  cnt_q <= 4'h0;
                  st_q <= hdr_hit ? S_TA : S_IDLE;
                  rd_q <= is_rd;
                  c45_q <= ~hdr_w[12];
                  op_q <= hdr_w[11:10];
                  reg_q <= hdr_w[4:0];
                  sh_q <= rd_val;
               end
            end
            S_TA:
            begin
               cnt_q <= cnt_q + 4'h1;
               if (rd_q && cnt_q == 4'h0)
               begin
                  mdio_oe_o <= 1'b1;
                  mdio_o <= 1'b0;
               end
               if (cnt_q == 4'h1)
               begin
                  cnt_q <= 4'h0;
                  st_q <= S_DAT;
                  if (rd_q)
                  begin
                     mdio_o <= sh_q[15];
                     sh_q <= {sh_q[14:0], 1'b0};
                  end
               end
            end
            S_DAT:
            begin
               cnt_q <= cnt_q + 4'h1;
               if (rd_q)
               begin
                  mdio_o <= sh_q[15];
                  sh_q <= {sh_q[14:0], 1'b0};
               end
               else
                  sh_q <= wr_val;
               if (cnt_q == DAT_LAST)
               begin
                  st_q <= S_IDLE;
                  mdio_oe_o <= 1'b0;
                  mdio_o <= 1'b1;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // register writes and address pointer
   logic wr22;
   logic wr45a;
   assign wr22 = wr_done & ~c45_q & (op_q == OP22_WR);
   assign wr45a = wr_done & c45_q & (op_q == OP45_ADR) & (reg_q == C45_DEV);
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ctl_q <= REG_RST;
         page_q <= REG_RST;
         ext19_q <= REG_RST;
         c45a_q <= REG_RST;
      end
      else
      begin
         if (wr22 && reg_q == R_CTRL)
            ctl_q <= wr_val;
         if (wr22 && reg_q == R_PAGE)
            page_q <= wr_val;
         if (wr22 && reg_q == R_FLF && page_q == PG_FLF)
            ext19_q <= wr_val;
         if (wr45a)
            c45a_q <= wr_val;
         else if (rd_go && !hdr_w[12] && hdr_w[11:10] == OP45_RDI
                  && hdr_w[4:0] == C45_DEV && page0)
            c45a_q <= c45a_q + 16'h0001;
      end
   end

   // ==========================================================
   // clear-on-read status; an event in the clearing cycle survives
   logic c45_rd;
   logic clr_eee;
   logic clr_lpi;
   assign c45_rd = rd_go & ~hdr_w[12] & (hdr_w[4:0] == C45_DEV) & page0;
   assign clr_eee = c45_rd & (c45a_q == C45_EEE);
   assign clr_lpi = c45_rd & (c45a_q == C45_PCS);
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         eee_q <= REG_RST;
         lpi_rx_q <= 1'b0;
         lpi_tx_q <= 1'b0;
      end
      else
      begin
         if (clr_eee)
            eee_q <= {15'h0000, wake_err_i};
         else if (wake_err_i && eee_q != 16'hFFFF)
            eee_q <= eee_q + 16'h0001;
         lpi_rx_q <= rx_lpi_i | (lpi_rx_q & ~clr_lpi);
         lpi_tx_q <= tx_lpi_i | (lpi_tx_q & ~clr_lpi);
      end
   end

   // ==========================================================
   // apb slave, one wait state
   logic pready_q;
   logic acc;
   logic [31:0] apb_rd;
   logic apb_err;
   logic [IRQ_W-1:0] irq_q;
   logic [IRQ_W-1:0] mask_q;
   logic [IRQ_W-1:0] ev;
   assign acc = psel_i & penable_i & pready_q;
   always_comb
   begin
      apb_rd = 32'h0;
      apb_err = 1'b0;
      unique case (paddr_i)
         A_CTRL: apb_rd[1:0] = apb_ctl_q;
         A_STAT:
         begin
            apb_rd[15:0] = page_q;
            apb_rd[STAT_LOOP] = loopback_o;
            apb_rd[STAT_FLF] = flf_en_o[0];
            apb_rd[STAT_FIB] = fiber_link_i & ~apb_ctl_q[CTRL_FX];
         end
         A_IRQ: apb_rd[IRQ_W-1:0] = irq_q;
         A_MASK: apb_rd[IRQ_W-1:0] = mask_q;
         A_C45A: apb_rd[15:0] = c45a_q;
         default: apb_err = 1'b1;
      endcase
   end
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         pready_q <= 1'b0;
         prdata_o <= 32'h0;
         pslverr_o <= 1'b0;
      end
      else
      begin
         pready_q <= psel_i & penable_i & ~pready_q;
         if (psel_i && penable_i && !pready_q)
         begin
            prdata_o <= pwrite_i ? 32'h0 : apb_rd;
            pslverr_o <= apb_err;
         end
      end
   end
   assign pready_o = pready_q;

   // ==========================================================
   // control, interrupts and outputs
   // only the setting of a sticky lpi bit is an event, so a held bit can be cleared
   assign ev = {(rx_lpi_i & ~lpi_rx_q) | (tx_lpi_i & ~lpi_tx_q),
                rd_go, wr_done};
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         apb_ctl_q <= CTRL_RST;
         mask_q <= MASK_RST;
         irq_q <= '0;
         irq_o <= 1'b0;
         loopback_o <= 1'b0;
         flf_en_o <= 4'h0;
      end
      else
      begin
         if (acc && pwrite_i && paddr_i == A_CTRL)
            apb_ctl_q <= pwdata_i[1:0];
         if (acc && pwrite_i && paddr_i == A_MASK)
            mask_q <= pwdata_i[IRQ_W-1:0];
         if (acc && pwrite_i && paddr_i == A_IRQ)
            irq_q <= ev | (irq_q & ~pwdata_i[IRQ_W-1:0]);
         else
            irq_q <= ev | irq_q;
         irq_o <= |(irq_q & mask_q);
         // loopback is forced off while media sensing owns the path
         loopback_o <= ctl_q[LOOP_BIT] & ~apb_ctl_q[CTRL_AUTO_MEDIA];
         flf_en_o <= {4{ext19_q[FLF_BIT]}};
      end
   end
endmodule : pmg_top

// File: sim/pmg_chk.sv
/* port checker for pmg_top.
   assumes clk_i at 100 MHz and a management clock of 80 ns. */
`timescale 1ns/1ps
module pmg_chk (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic mdio_o,
   input wire logic mdio_oe_o,
   input wire logic loopback_o,
   input wire logic [3:0] flf_en_o
);
   // ==========================================
   // drive length counter
   logic [7:0] oe_cnt_q;
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         oe_cnt_q <= 8'h00;
      else
         oe_cnt_q <= mdio_oe_o ? oe_cnt_q + 8'h01 : 8'h00;
   end
   // ==========================================
   // assertions
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   flf_all_a: assert property (flf_en_o == 4'h0 || flf_en_o == 4'hF)
      else $error("fast link fail enables differ");
   rdy_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
      else $error("no ready after one wait state");
   rdy_pulse_a: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   rdy_cause_a: assert property (pready_o |-> psel_i && penable_i)
      else $error("ready outside access");
   rdata_hold_a: assert property ($changed(prdata_o) |-> pready_o)
      else $error("read data moved without ready");
   ta_zero_a: assert property ($rose(mdio_oe_o) |-> !mdio_o)
      else $error("turnaround bit not zero");
   // 17 management periods, sync jitter on both ends
   oe_len_a: assert property ($fell(mdio_oe_o) |-> oe_cnt_q >= 8'h85 && oe_cnt_q <= 8'h8B)
      else $error("read drive length wrong");
   lb_quiet_a: assert property ($changed(loopback_o) |-> !mdio_oe_o)
      else $error("loopback moved during read");
endmodule : pmg_chk
bind pmg_top pmg_chk u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
   .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o), .mdio_o(mdio_o),
   .mdio_oe_o(mdio_oe_o), .loopback_o(loopback_o), .flf_en_o(flf_en_o));

// File: sim/pmg_sta_mgr.sv
/* station manager model: makes mdc and drives the data line.
   assumes the bench resolves the pulled-up wire into mdio_w_i. */
`timescale 1ns/1ps
module pmg_sta_mgr (
   output logic mdc_o,
   output logic mdio_m_o,
   input wire logic mdio_w_i
);
   // ==========================================
   // frames; mdc stands low between them
   initial
   begin
      mdc_o = 1'b0;
      mdio_m_o = 1'b1;
   end
   task automatic frame(input logic [1:0] st, op, input logic [4:0] ra,
      input logic [15:0] wd, output logic [16:0] rd);
      logic [63:0] f;
      int n;
      f = {32'hFFFFFFFF, st, op, 5'h00, ra, 2'h2, wd};
      n = op[1] ? 46 : 64;
      rd = 17'h00000;
      for (int i = 0; i < 64; i++)
      begin
         mdio_m_o = (i < n) ? f[63-i] : 1'b1;
         #40;
         if (i > 46)
            rd = {rd[15:0], mdio_w_i};
         mdc_o = 1'b1;
         #40 mdc_o = 1'b0;
      end
      // released line goes back to the pull-up level between frames
      mdio_m_o = 1'b1;
      #400;
   endtask : frame
endmodule : pmg_sta_mgr

// File: sim/tb_pmg_top.sv
/* bench for pmg_top: apb master, event pulses, station manager.
   assumes pmg_chk bound and pmg_sta_mgr on the management pins. */
`timescale 1ns/1ps
module tb_pmg_top import pmg_pkg::*;;
   // ==========================================
   // signals and instances
   logic clk_i, arst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
   logic mdc, mdio_m, mdio_w, mdio_o, mdio_oe_o, rx_lpi_i, tx_lpi_i, wake_err_i;
   logic fiber_link_i, loopback_o, irq_o;
   logic [7:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, q;
   logic [3:0] flf_en_o;
   logic [16:0] rd;
   int n_mismatch = 0;
   int tests_run = 0;
   assign mdio_w = (mdio_oe_o ? mdio_o : 1'b1) & mdio_m;
   pmg_top DUT (.clk_i, .arst_n_i, .paddr_i, .psel_i, .penable_i, .pwrite_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .mdc_i(mdc), .mdio_i(mdio_w),
      .mdio_o, .mdio_oe_o, .rx_lpi_i, .tx_lpi_i, .wake_err_i, .fiber_link_i,
      .loopback_o, .flf_en_o, .irq_o);
   pmg_sta_mgr u_mgr (.mdc_o(mdc), .mdio_m_o(mdio_m), .mdio_w_i(mdio_w));
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // ==========================================
   // shared tasks
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_i);
      paddr_i <= a;
      pwrite_i <= w;
      pwdata_i <= d;
      psel_i <= 1'b1;
      @(posedge clk_i);
      penable_i <= 1'b1;
      // no cycle count assumed; only the watchdog ends a hung wait
      do
      begin
         @(posedge clk_i);
      end
      while (pready_o !== 1'b1);
      q = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   task automatic md(input logic [1:0] st, op, input logic [4:0] ra, input logic [15:0] wd);
      // start on the falling edge so mdc edges never meet the sampling edge
      @(negedge clk_i);
      u_mgr.frame(st, op, ra, wd, rd);
   endtask : md
   task automatic ev(input logic w, r, t);
      @(posedge clk_i);
      wake_err_i <= w;
      rx_lpi_i <= r;
      tx_lpi_i <= t;
      @(posedge clk_i);
      {wake_err_i, rx_lpi_i, tx_lpi_i} <= 3'h0;
   endtask : ev
   // ==========================================
   // scenarios
   task automatic t_regs;
      apb(A_CTRL, 1'b0, 32'h0);
      chk("ctrl", q, {30'h0, CTRL_RST});
      apb(A_MASK, 1'b0, 32'h0);
      chk("mask", q, {29'h0, MASK_RST});
      apb(8'h14, 1'b0, 32'h0);
      chk("unmapped", {q[30:0], err}, 32'h1);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_eee;
      md(2'h1, OP22_WR, R_PAGE, 16'h0000);
      repeat (3) ev(1'b1, 1'b0, 1'b0);
      md(2'h0, OP45_ADR, C45_DEV, C45_EEE);
      md(2'h0, OP45_RD, C45_DEV, 16'h0000);
      chk("eee count", {15'h0, rd}, 32'h3);
      md(2'h0, OP45_RD, C45_DEV, 16'h0000);
      chk("eee clear", {15'h0, rd}, 32'h0);
      ev(1'b0, 1'b1, 1'b1);
      md(2'h0, OP45_ADR, C45_DEV, C45_PCS);
      md(2'h0, OP45_RDI, C45_DEV, 16'h0000);
      chk("lpi", {15'h0, rd}, (32'h1 << LPI_RX_BIT) | (32'h1 << LPI_TX_BIT));
      apb(A_C45A, 1'b0, 32'h0);
      chk("c45 inc", q, {16'h0, C45_PCS + 16'h1});
      md(2'h0, OP45_ADR, C45_DEV, C45_PCS);
      md(2'h0, 2'h1, C45_DEV, 16'h0000);
      apb(A_C45A, 1'b0, 32'h0);
      chk("c45 wr", q, {16'h0, C45_PCS});
      md(2'h0, OP45_RD, C45_DEV, 16'h0000);
      chk("lpi clear", {15'h0, rd}, 32'h0);
      $display("t_eee done");
   endtask : t_eee
   task automatic t_page;
      @(posedge clk_i) fiber_link_i <= 1'b1;
      md(2'h1, OP22_WR, R_PAGE, PG_FSTAT);
      ev(1'b1, 1'b0, 1'b0);
      md(2'h0, OP45_ADR, C45_DEV, C45_EEE);
      md(2'h0, OP45_RDI, C45_DEV, 16'h0000);
      chk("eee hidden", {15'h0, rd}, 32'h0);
      apb(A_C45A, 1'b0, 32'h0);
      chk("c45 held", q, {16'h0, C45_EEE});
      apb(A_STAT, 1'b0, 32'h0);
      chk("page", {16'h0, q[15:0]}, {16'h0, PG_FSTAT});
      md(2'h1, OP22_RD, R_FSTAT, 16'h0000);
      chk("fiber", {15'h0, rd}, 32'h1 << FSTAT_BIT);
      apb(A_CTRL, 1'b1, 32'h1 << CTRL_FX);
      md(2'h1, OP22_RD, R_FSTAT, 16'h0000);
      chk("fx hidden", {15'h0, rd}, 32'h0);
      md(2'h1, OP22_WR, R_PAGE, 16'h0000);
      md(2'h0, OP45_RD, C45_DEV, 16'h0000);
      chk("eee kept", {15'h0, rd}, 32'h1);
      $display("t_page done");
   endtask : t_page
   task automatic t_ctl;
      md(2'h1, OP22_WR, R_PAGE, PG_FLF);
      md(2'h1, OP22_WR, R_FLF, 16'h1 << FLF_BIT);
      chk("flf", {28'h0, flf_en_o}, 32'hF);
      apb(A_CTRL, 1'b1, 32'h1 << CTRL_AUTO_MEDIA);
      md(2'h1, OP22_WR, R_CTRL, 16'h1 << LOOP_BIT);
      chk("loop media", {31'h0, loopback_o}, 32'h0);
      apb(A_CTRL, 1'b1, 32'h0);
      repeat (2) @(posedge clk_i);
      chk("loop", {31'h0, loopback_o}, 32'h1);
      apb(A_STAT, 1'b0, 32'h0);
      chk("stat flf", {31'h0, q[STAT_FLF]}, 32'h1);
      chk("stat loop", {31'h0, q[STAT_LOOP]}, 32'h1);
      $display("t_ctl done");
   endtask : t_ctl
   task automatic t_irq;
      apb(A_IRQ, 1'b0, 32'h0);
      chk("irq st", q, 32'h7);
      chk("irq masked", {31'h0, irq_o}, 32'h0);
      apb(A_MASK, 1'b1, 32'h1 << IRQ_WR);
      repeat (2) @(posedge clk_i);
      chk("irq on", {31'h0, irq_o}, 32'h1);
      apb(A_IRQ, 1'b1, 32'h7);
      repeat (2) @(posedge clk_i);
      chk("irq off", {31'h0, irq_o}, 32'h0);
      $display("t_irq done");
   endtask : t_irq
   // ==========================================
   // sequence, watchdog, verdict
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up
   initial
   begin
      {arst_n_i, psel_i, penable_i, pwrite_i, err} = 5'h00;
      {rx_lpi_i, tx_lpi_i, wake_err_i, fiber_link_i} = 4'h0;
      paddr_i = 8'h00;
      pwdata_i = 32'h0;
      repeat (3) @(posedge clk_i);
      arst_n_i <= 1'b1;
      t_regs();
      t_eee();
      t_page();
      t_ctl();
      t_irq();
      wrap_up();
   end
   // about 19 frames of 5.5 us each
   initial
   begin
      #500000;
      n_mismatch++;
      wrap_up();
   end
endmodule : tb_pmg_top
